/* File: common/wit_pkg.sv */
// Package with the watch interval timer constants shared by the design files.
package wit_pkg;
  // System clock rate in hertz.
  localparam int WIT_CLK_HZ = 40000000;
  // Subsystem clock rate in hertz, the second watch clock source.
  localparam int WIT_SUB_CLOCK_FREQ_HZ = 32768;
  // Byte address of the watch control register on the register port.
  localparam logic [15:0] WIT_CTRL_ADDR = 16'hff4a;
  // Control register value after reset.
  localparam logic [7:0] WIT_CTRL_RESET = 8'h00;
  // Bits that software can write; bits 3 and 2 always read as zero.
  localparam logic [7:0] WIT_CTRL_MASK = 8'hf3;
  // Field positions inside the control register.
  localparam int WIT_BIT_ENABLE = 0;
  localparam int WIT_BIT_RUN = 1;
  localparam int WIT_SEL_LSB = 4;
  localparam int WIT_BIT_SRC = 7;
  // The main clock is divided by 2^7 = 128 to form the watch clock.
  localparam int WIT_MAIN_DIV_BITS = 7;
  // Prescaler and counter widths.
  localparam int WIT_PRE_BITS = 9;
  localparam int WIT_CNT_BITS = 5;
  // Interval code 0 gives 2^4 watch clock periods; the largest legal code is 5.
  localparam int WIT_INTERVAL_MIN_EXP = 4;
  localparam logic [2:0] WIT_SEL_MAX = 3'h5;
endpackage

/* File: hw/wit_prescaler.sv */
// Nine-bit watch prescaler with interval tap selection and final-stage carry.
`timescale 1ns/1ps
module wit_prescaler #(
  parameter int PRE_W = 9
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Control.
  input wire logic clear,
  input wire logic tick,
  input wire logic [2:0] sel,
  // Event pulses, one cycle each.
  output logic interval_pulse,
  output logic carry_pulse
);
  import wit_pkg::*;

  logic [PRE_W-1:0] pre_q, pre_d; // Prescaler stages.
  logic int_q, int_d; // Registered interval event.
  logic car_q, car_d; // Registered final-stage carry.
  logic tap_hit; // All stages below the selected tap are ones.

  // Next-state logic: count watch clock ticks and detect tap roll-overs.
  always_comb begin
    int k;
    k = WIT_INTERVAL_MIN_EXP + int'(sel);
    tap_hit = 1'b1;
    for (int i = 0; i < PRE_W; i++) begin
      if (i < k) begin
        tap_hit = tap_hit & pre_q[i];
      end
    end
    pre_d = pre_q;
    int_d = 1'b0;
    car_d = 1'b0;
    if (clear) begin
      // Clearing drops any pending tick so no stray event leaves.
      pre_d = '0;
    end else if (tick) begin
      pre_d = pre_q + 1'b1;
      // Prohibited codes produce no interval event at all.
      int_d = tap_hit && (sel <= WIT_SEL_MAX);
      car_d = &pre_q;
    end
  end

  // State registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pre_q <= '0;
      int_q <= 1'b0;
      car_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      int_q <= int_d;
      car_q <= car_d;
    end
  end

  assign interval_pulse = int_q;
  assign carry_pulse = car_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // A prohibited code must never produce an interval event.
  property p_prohibited_quiet;
    (sel > WIT_SEL_MAX) && !clear |=> !int_q;
  endproperty
  a_prohibited_quiet: assert property (p_prohibited_quiet) else $error("interval event on prohibited code");

  // The carry follows the tick that wraps the prescaler to zero.
  property p_carry_wrap;
    tick && !clear && (&pre_q) |=> car_q && (pre_q == '0);
  endproperty
  a_carry_wrap: assert property (p_carry_wrap) else $error("prescaler wrap without carry");
endmodule

/* File: hw/wit_top.sv */
// Watch interval timer: control register, clock selection, watch counter and interrupt.
`timescale 1ns/1ps

// Behaviour
// - Source bit picks main/128 or subsystem clock.
// - Interval code selects 2^4..2^9; 110/111 prohibited.
// - Run bit counts counter; zero stops and clears.
// - Enable zero stops, clears prescaler and counter.
// - Run clear restarts count, prescaler untouched.
// - Watch interrupt every 2^14 watch ticks; half a second only on subsystem clock.
// - Interval interrupt repeats while enabled.
// - Watch and interval share prescaler and line.
// - Counter starts one prescaler cycle late.
// - Reset clears control register to zero.
// - Byte writes and single-bit writes accepted.
module wit_top (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Subsystem clock pin, asynchronous to clock.
  input wire logic sub_clock_pin,
  // Register port.
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Single-bit write port.
  input wire logic reg_bit_wr,
  input wire logic [2:0] reg_bit_sel,
  input wire logic reg_bit_val,
  // Shared interrupt request, one-cycle pulse.
  output logic watch_irq
);
  import wit_pkg::*;

  // Control register and its decoded fields.
  logic [7:0] watch_control_reg_q, watch_control_reg_d;
  logic clock_source_sel; // Watch clock source.
  logic [2:0] interval_sel; // Interval code.
  logic counter_run; // Five-bit counter run.
  logic timer_enable; // Whole timer enable.
  logic addr_hit; // Register port addresses this register.

  // Read data path.
  logic [7:0] rdata_q, rdata_d;

  // Subsystem clock synchroniser and filtered level.
  logic sub_s1_q, sub_s2_q, sub_s3_q;
  logic sub_lvl_q, sub_lvl_d;
  logic sub_tick; // One cycle per subsystem clock rising edge.

  // Main clock divider by 128.
  logic [WIT_MAIN_DIV_BITS-1:0] div_q, div_d;
  logic main_tick;
  logic fw_tick; // Selected watch clock tick.

  // Prescaler outputs.
  logic interval_pulse;
  logic carry_pulse;

  // Five-bit counter and start-delay flag.
  logic [WIT_CNT_BITS-1:0] cnt_q, cnt_d;
  logic armed_q, armed_d;
  logic watch_evt; // Counter overflow this cycle.
  logic irq_q, irq_d;

  assign clock_source_sel = watch_control_reg_q[WIT_BIT_SRC];
  assign interval_sel = watch_control_reg_q[WIT_SEL_LSB +: 3];
  assign counter_run = watch_control_reg_q[WIT_BIT_RUN];
  assign timer_enable = watch_control_reg_q[WIT_BIT_ENABLE];
  assign addr_hit = (reg_addr == WIT_CTRL_ADDR);

  // Register writes: a whole byte, or a single bit; reserved bits stay zero.
  always_comb begin
    watch_control_reg_d = watch_control_reg_q;
    if (reg_wr && addr_hit) begin
      watch_control_reg_d = reg_wdata & WIT_CTRL_MASK;
    end else if (reg_bit_wr && addr_hit) begin
      watch_control_reg_d[reg_bit_sel] = reg_bit_val;
      watch_control_reg_d = watch_control_reg_d & WIT_CTRL_MASK;
    end
    // Read data live only in the cycle after the strobe; unmapped reads give zero.
    rdata_d = 8'h00;
    if (reg_rd && addr_hit) begin
      rdata_d = watch_control_reg_q;
    end
  end

  // Register file flip-flops.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watch_control_reg_q <= WIT_CTRL_RESET;
      rdata_q <= 8'h00;
    end else begin
      watch_control_reg_q <= watch_control_reg_d;
      rdata_q <= rdata_d;
    end
  end

  // Synchroniser: only the second stage reads the first; the filtered level
  // moves once the second and third stages agree, which rejects a single-cycle glitch.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      sub_s1_q <= sub_clock_pin;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  // Filtered level and tick generation for both watch clock sources.
  always_comb begin
    sub_lvl_d = sub_lvl_q;
    if (sub_s2_q == sub_s3_q) begin
      sub_lvl_d = sub_s3_q;
    end
    sub_tick = sub_lvl_d && !sub_lvl_q;
    // The divider is held cleared while stopped so the first period is full length.
    div_d = div_q + 1'b1;
    if (!timer_enable || clock_source_sel) begin
      div_d = '0;
    end
    main_tick = timer_enable && !clock_source_sel && (&div_q);
    fw_tick = clock_source_sel ? (timer_enable && sub_tick) : main_tick;
  end

  // Source selection registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sub_lvl_q <= 1'b0;
      div_q <= '0;
    end else begin
      sub_lvl_q <= sub_lvl_d;
      div_q <= div_d;
    end
  end

  // Shared prescaler feeds both the interval tap and the counter carry.
  wit_prescaler #(
    .PRE_W(WIT_PRE_BITS)
  ) u_prescaler (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(!timer_enable),
    .tick(fw_tick),
    .sel(interval_sel),
    .interval_pulse(interval_pulse),
    .carry_pulse(carry_pulse)
  );

  // Counter: the first carry after start only arms it, so the first watch
  // event lands one prescaler period late; later ones come every 2^14 ticks.
  always_comb begin
    cnt_d = cnt_q;
    armed_d = armed_q;
    watch_evt = 1'b0;
    if (!timer_enable || !counter_run) begin
      // Run clear restarts from zero; the prescaler keeps going.
      cnt_d = '0;
      armed_d = 1'b0;
    end else if (carry_pulse) begin
      if (!armed_q) begin
        armed_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
        watch_evt = &cnt_q;
      end
    end
    // Both events share the one request line.
    irq_d = watch_evt || (timer_enable && interval_pulse);
  end

  // Counter and interrupt registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign watch_irq = irq_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Control register is zero right after reset release.
  property p_reset_clear;
    $past(sys_rst) |-> watch_control_reg_q == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset");

  // A byte write lands masked in the next cycle.
  property p_byte_write;
    reg_wr && addr_hit |=> watch_control_reg_q == ($past(reg_wdata) & WIT_CTRL_MASK);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write not stored");

  // A bit write changes only the addressed writable bit.
  property p_bit_write;
    reg_bit_wr && !reg_wr && addr_hit && WIT_CTRL_MASK[reg_bit_sel]
      |=> watch_control_reg_q[$past(reg_bit_sel)] == $past(reg_bit_val);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write not stored");

  // Read data reflect the register one cycle after the strobe, zero otherwise.
  property p_read_data;
    reg_rd && addr_hit |=> reg_rdata == $past(watch_control_reg_q);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  // Disabled timer holds the counter at zero and disarmed.
  property p_disable_clear;
    !timer_enable |=> cnt_q == '0 && !armed_q;
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("disable did not clear");

  // Run bit low keeps the counter at zero.
  property p_run_clear;
    !counter_run |=> cnt_q == '0;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("counter not cleared");

  // The first carry after start arms without counting.
  property p_late_start;
    carry_pulse && timer_enable && counter_run && !armed_q |=> armed_q && cnt_q == '0;
  endproperty
  a_late_start: assert property (p_late_start) else $error("counter started early");

  // Overflow step: counter at 31 with a carry; in the very next cycle the counter
  // has wrapped to zero and the request pulse stands, both from the same edge.
  sequence s_overflow;
    timer_enable && counter_run && armed_q && (&cnt_q) && carry_pulse;
  endsequence
  sequence s_irq_pulse;
    cnt_q == '0 && watch_irq;
  endsequence
  property p_watch_irq;
    s_overflow |=> s_irq_pulse;
  endproperty
  a_watch_irq: assert property (p_watch_irq) else $error("watch overflow lost");

  // An interval event while enabled reaches the request line next cycle.
  property p_interval_irq;
    interval_pulse && timer_enable |=> watch_irq;
  endproperty
  a_interval_irq: assert property (p_interval_irq) else $error("interval event lost");

  // Main source: no second watch clock tick comes eight system cycles after a tick.
  property p_main_tick;
    timer_enable && !clock_source_sel && main_tick ##1 (timer_enable && !clock_source_sel)[*8]
      |-> !main_tick;
  endproperty
  a_main_tick: assert property (p_main_tick) else $error("main divider too fast");

  // Read data fall back to zero after any cycle without an addressed read.
  property p_rdata_idle;
    !(reg_rd && addr_hit) |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

  // The two unused bits can never be set, whatever software writes.
  property p_reserved_zero;
    watch_control_reg_q[3:2] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bits set");

  // With the subsystem source picked, the main divider must stay silent.
  property p_src_gate;
    clock_source_sel |-> !main_tick;
  endproperty
  a_src_gate: assert property (p_src_gate) else $error("main tick while subsystem source selected");

  // A stopped timer raises no request from the cycle after the stop; a request registered in the last enabled cycle still shows in the first stopped one.
  property p_off_quiet;
    !timer_enable |=> !watch_irq;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("request while timer stopped");
endmodule

/* File: dv/wit_top_tb_top.sv */
// Self-checking bench for the watch interval timer register port and interrupt timing.
`timescale 1ns/1ps
module wit_top_tb_top;
  import wit_pkg::*;
  // Design inputs, all given a value at time zero.
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic sub_clock_pin = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_bit_wr = 1'b0;
  logic [2:0] reg_bit_sel = 3'h0;
  logic reg_bit_val = 1'b0;
  // Design outputs.
  logic [7:0] reg_rdata;
  logic watch_irq;
  // Bench bookkeeping.
  int error_cnt = 0;
  int samples_checked = 0;
  logic sub_div = 1'b0;
  // System cycles per subsystem watch tick made by the stand-in below.
  localparam int SUB_TICK_CYC = 4;
  logic [7:0] rv;
  int n;

  wit_top dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .sub_clock_pin(sub_clock_pin),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_bit_wr(reg_bit_wr),
    .reg_bit_sel(reg_bit_sel),
    .reg_bit_val(reg_bit_val),
    .watch_irq(watch_irq)
  );

  // The 40 MHz system clock.
  always #12.5 clock = ~clock;

  // Subsystem clock stand-in: the pin toggles every second cycle, the fastest rate the
  // three-stage filter still follows, so a watch tick comes every 4 cycles and the run stays short.
  always @(posedge clock) begin
    sub_div <= ~sub_div;
    if (sub_div) begin
      sub_clock_pin <= ~sub_clock_pin;
    end
  end

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle byte write on the register port.
  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // One-cycle single-bit write to the control register.
  task automatic bit_write(input logic [2:0] b, input logic v);
    @(posedge clock);
    reg_addr <= WIT_CTRL_ADDR;
    reg_bit_sel <= b;
    reg_bit_val <= v;
    reg_bit_wr <= 1'b1;
    @(posedge clock);
    reg_bit_wr <= 1'b0;
  endtask

  // One-cycle read; data is taken in the following cycle, the only one where it stands.
  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Counts cycles to the next interrupt pulse, giving up after lim cycles.
  task automatic irq_gap(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      #1;
      cnt++;
    end while (watch_irq !== 1'b1 && cnt < lim);
  endtask

  // Waits for a pulse that must come; a hang ends the run.
  task automatic sync_irq(input int lim);
    int c;
    irq_gap(lim, c);
    if (c >= lim) begin
      error_cnt++;
      $display("unexpected at %0t: no pulse within %h cycles", $time, lim);
      close_out();
    end
  endtask

  // Reset value, reserved bits, unmapped address and single-bit writes.
  task automatic s_regs();
    reg_read(WIT_CTRL_ADDR, rv);
    chk({24'h0, rv}, 32'h00);
    reg_write(WIT_CTRL_ADDR, 8'hff);
    reg_write(16'hff4b, 8'h00);
    reg_read(WIT_CTRL_ADDR, rv);
    chk({24'h0, rv}, 32'hf3);
    @(posedge clock);
    #1;
    chk({24'h0, reg_rdata}, 32'h00);
    reg_read(16'hff4b, rv);
    chk({24'h0, rv}, 32'h00);
    bit_write(3'h0, 1'b0);
    bit_write(3'h3, 1'b1);
    reg_read(WIT_CTRL_ADDR, rv);
    chk({24'h0, rv}, 32'hf2);
    reg_write(WIT_CTRL_ADDR, 8'h00);
  endtask

  // Steady interval period for the first two codes from the main clock divided by 128.
  task automatic s_intervals();
    for (int c = 0; c < 2; c++) begin
      reg_write(WIT_CTRL_ADDR, {1'b0, c[2:0], 4'h3});
      sync_irq(20000);
      irq_gap(20000, n);
      chk(n, 128 << (4 + c));
      reg_write(WIT_CTRL_ADDR, 8'h00);
    end
  endtask

  // Prohibited codes give no interval pulse at all; the fast subsystem source makes the window
  // longer than one prescaler wrap, where a decoder reading them as longer intervals would fire.
  task automatic s_prohibited();
    for (int c = 6; c < 8; c++) begin
      reg_write(WIT_CTRL_ADDR, {1'b1, c[2:0], 4'h3});
      irq_gap(2500, n);
      chk(n, 2500);
    end
    reg_write(WIT_CTRL_ADDR, 8'h00);
  endtask

  // Clearing run keeps the prescaler; clearing enable stops everything.
  task automatic s_stop();
    reg_write(WIT_CTRL_ADDR, 8'h03);
    sync_irq(5000);
    bit_write(3'h1, 1'b0);
    irq_gap(5000, n);
    chk(n + 2, 2048);
    bit_write(3'h0, 1'b0);
    irq_gap(5000, n);
    chk(n, 5000);
  endtask

  // Subsystem source: one watch tick per stand-in pin period, for the first three codes.
  task automatic s_subsrc();
    for (int c = 0; c < 3; c++) begin
      reg_write(WIT_CTRL_ADDR, {1'b1, c[2:0], 4'h3});
      sync_irq(2000);
      irq_gap(2000, n);
      chk(n, SUB_TICK_CYC << (WIT_INTERVAL_MIN_EXP + c));
      reg_write(WIT_CTRL_ADDR, 8'h00);
    end
  endtask

  // Watch overflow alone on the line: a prohibited code silences the interval side, so the first
  // pulse is the counter overflow, 33 prescaler wraps after start since the first wrap only arms.
  // The window of four cycles covers the unknown phase of the pin against the enabling write.
  task automatic s_watch();
    int base;
    base = ((1 << WIT_CNT_BITS) + 1) * (1 << WIT_PRE_BITS) * SUB_TICK_CYC;
    reg_write(WIT_CTRL_ADDR, 8'he3);
    irq_gap(base + 100, n);
    chk((n >= base - 2 && n <= base + 1) ? base : n, base);
    reg_write(WIT_CTRL_ADDR, 8'h00);
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    s_regs();
    s_intervals();
    s_prohibited();
    s_stop();
    s_subsrc();
    s_watch();
    close_out();
  end
endmodule
